//--- logic/svmc_defs.svh
// Offsets, bit positions and timing figures for the supply-monitor host.
// Assumes a 125 MHz system clock and byte addresses on both buses.
`ifndef SVMC_DEFS_SVH
`define SVMC_DEFS_SVH
// Own registers, reached by software over APB
`define A_CFG     8'h00
`define A_CMD     8'h04
`define A_STAT    8'h08
// Device registers, reached over the device port
`define D_MONEN   8'h00
`define D_DETCTL  8'h04
`define D_CLK1    8'h08
`define D_M1CTL   8'h0C
`define D_M2CTL   8'h10
// Monitor control, shared enable, detector control and clock register fields
`define B_EN      0
`define B_BYP     1
`define B_FLAG    2
`define B_FSEL    4
`define B_RSEL    6
`define B_EDGE    7
`define B_SHARED  0
`define B_DET1    6
`define B_DET2    7
`define B_OSCSTOP 4
// Configuration register fields
`define C_MON     0
`define C_FILT    1
`define C_RST     2
`define C_EDGE    3
`define C_FSEL    4
`define C_DISC    6
`define C_W       7
// Command and status fields
`define K_SETUP   0
`define K_POLL    1
`define K_CLR     2
`define S_BUSY    0
`define S_F1      1
`define S_F2      2
`define S_ERR     3
`define S_DONE    4
`define S_W       5
// Timing
`define CLK_MHZ   125
`define LOCO_KHZ  125
`define FILT_CLKS 3
`define SETTLE_US 100
`endif

//--- logic/svmc_pkg.sv
// Types shared by the supply-monitor host modules.
// Assumes nothing of its surroundings.
package svmc_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_SHARED, S_DETRD, S_DETWR, S_SETTLE, S_CFG,
      S_CLRF, S_OSCRD, S_OSCWR, S_FWAIT, S_ENABLE, S_RDFLAG,
      S_DISCARD, S_POLL, S_CLRRD, S_CLRWR
   } seq_t;
   typedef enum logic [1:0] {
      M_IDLE, M_SETUP, M_ACCESS, M_DONE
   } mst_t;
endpackage

//--- logic/dev_req_if.sv
// Request and answer carrier between sequencer and device-port engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dev_req_if;
   logic        req;
   logic        wr;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        ack;
   logic        err;
   logic [31:0] rdata;
   modport seq (output req, wr, addr, wdata, input ack, err, rdata);
   modport eng (input req, wr, addr, wdata, output ack, err, rdata);
endinterface
`default_nettype wire

//--- logic/apb_master_eng.sv
// APB master that runs one device register access per request.
// Assumes the requester holds its request until ack and the slave is on clk.
`timescale 1ns/1ps
`default_nettype none
module apb_master_eng (
   input  wire logic        clk,
   input  wire logic        rst_n,
   dev_req_if.eng           rq,
   output var  logic [7:0]  mPaddr,
   output var  logic        mPsel,
   output var  logic        mPenable,
   output var  logic        mPwrite,
   output var  logic [31:0] mPwdata,
   input  wire logic [31:0] mPrdata,
   input  wire logic        mPready,
   input  wire logic        mPslverr
);
   svmc_pkg::mst_t st_ff;
   logic           ack_ff;
   logic           err_ff;
   logic [31:0]    rdata_ff;
   wire            done = (st_ff == svmc_pkg::M_ACCESS) & mPready;

   assign rq.ack   = ack_ff;
   assign rq.err   = err_ff;
   assign rq.rdata = rdata_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff    <= svmc_pkg::M_IDLE;
         mPsel    <= 1'b0;
         mPenable <= 1'b0;
         mPwrite  <= 1'b0;
         mPaddr   <= 8'h00;
         mPwdata  <= 32'h0000_0000;
         ack_ff   <= 1'b0;
         err_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= done;
         unique case (st_ff)
            svmc_pkg::M_IDLE: if (rq.req) begin
               st_ff   <= svmc_pkg::M_SETUP;
               mPsel   <= 1'b1;
               mPwrite <= rq.wr;
               mPaddr  <= rq.addr;
               mPwdata <= rq.wdata;
            end
            svmc_pkg::M_SETUP: begin
               st_ff    <= svmc_pkg::M_ACCESS;
               mPenable <= 1'b1;
            end
            svmc_pkg::M_ACCESS: if (mPready) begin
               st_ff    <= svmc_pkg::M_DONE;
               mPsel    <= 1'b0;
               mPenable <= 1'b0;
               rdata_ff <= mPrdata;
               err_ff   <= mPslverr;
            end
            svmc_pkg::M_DONE: st_ff <= svmc_pkg::M_IDLE;
         endcase
      end
   end

   property p_setup_then_access;
      @(posedge clk) disable iff (!rst_n)
      mPsel && !mPenable |=> mPsel && mPenable;
   endproperty
   a_setup_then_access: assert property (p_setup_then_access)
      else $error("setup cycle not followed by access phase");

   property p_hold_while_wait;
      @(posedge clk) disable iff (!rst_n)
      mPsel && mPenable && !mPready |=>
         $stable(mPaddr) && $stable(mPwdata) && $stable(mPwrite) && mPenable;
   endproperty
   a_hold_while_wait: assert property (p_hold_while_wait)
      else $error("request changed before pready");

   property p_ack_after_ready;
      @(posedge clk) disable iff (!rst_n)
      mPsel && mPenable && mPready |=> ack_ff && !mPsel ##1 !ack_ff;
   endproperty
   a_ack_after_ready: assert property (p_ack_after_ready)
      else $error("ack not a single pulse after pready");
endmodule
`default_nettype wire

//--- logic/supply_voltage_monitor_ctrl.sv
// Host sequencer that sets up and services two supply-voltage monitors.
// Assumes software on an APB slave port and the device registers on an
// APB master port, both on clk.
//
// The address map and the APB interface to the registers were left to the implementer.
`include "svmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor_ctrl #(
   parameter int SETTLE_CYC = `SETTLE_US * `CLK_MHZ,
   parameter int FILT_BASE  = `FILT_CLKS * `CLK_MHZ * 1000 / `LOCO_KHZ
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic [7:0]  mPaddr,
   output var  logic        mPsel,
   output var  logic        mPenable,
   output var  logic        mPwrite,
   output var  logic [31:0] mPwdata,
   input  wire logic [31:0] mPrdata,
   input  wire logic        mPready,
   input  wire logic        mPslverr
);
   dev_req_if rq ();

   svmc_pkg::seq_t      st_ff;
   svmc_pkg::seq_t      nxt_st;
   logic [`C_W-1:0]     cfg_ff;
   logic [`C_W-1:0]     run_ff;
   logic [1:0]          flag_ff;
   logic                err_ff;
   logic                done_ff;
   logic [31:0]         rmw_ff;
   logic [15:0]         wait_ff;
   logic                clrDone_ff;
   logic [15:0]         spent_ff;
   logic [7:0]          ctlBase;
   logic [31:0]         wdMux;

   // Software port: one wait-free access phase per transfer
   wire setupPh = psel & ~penable;
   wire accWr   = psel & penable & pwrite & pready;
   wire hitCfg  = paddr == `A_CFG;
   wire hitCmd  = paddr == `A_CMD;
   wire hitStat = paddr == `A_STAT;
   wire mapped  = hitCfg | hitCmd | hitStat;
   wire idle    = st_ff == svmc_pkg::S_IDLE;
   wire cmdWr   = accWr & hitCmd & idle;
   wire goSetup = cmdWr & pwdata[`K_SETUP];
   wire goPoll  = cmdWr & ~pwdata[`K_SETUP] & pwdata[`K_POLL];
   wire goClr   = cmdWr & ~pwdata[`K_SETUP] & ~pwdata[`K_POLL]
                  & pwdata[`K_CLR];
   wire goAny   = goSetup | goPoll | goClr;

   logic [`S_W-1:0] stat;
   always_comb begin
      stat = '0;
      stat[`S_BUSY] = ~idle;
      stat[`S_F1]   = flag_ff[0];
      stat[`S_F2]   = flag_ff[1];
      stat[`S_ERR]  = err_ff;
      stat[`S_DONE] = done_ff;
   end

   wire [31:0] rdMux = hitCfg  ? 32'(cfg_ff) :
                       hitStat ? 32'(stat)   : 32'h0000_0000;

   // Run settings, frozen at command start
   wire       mon2    = run_ff[`C_MON];
   wire       useFilt = run_ff[`C_FILT];
   wire       rstUse  = run_ff[`C_RST];
   wire [1:0] fsel    = run_ff[`C_FSEL+1:`C_FSEL];
   wire       edgeEff = rstUse | run_ff[`C_EDGE];
   wire [7:0] ctlAddr = mon2 ? `D_M2CTL : `D_M1CTL;
   wire [15:0] filtCyc = 16'(FILT_BASE) << fsel;
   wire        ackOk  = rq.ack & ~rq.err;

   // Monitor control image; flag writes of one leave the flag alone
   always_comb begin
      ctlBase = 8'h00;
      ctlBase[`B_EDGE]              = edgeEff;
      ctlBase[`B_RSEL]              = rstUse;
      ctlBase[`B_FSEL+1:`B_FSEL]    = fsel;
      ctlBase[`B_BYP]               = ~useFilt;
      ctlBase[`B_FLAG]              = 1'b1;
   end

   // Device access decode
   wire isRd = st_ff == svmc_pkg::S_DETRD  || st_ff == svmc_pkg::S_OSCRD ||
               st_ff == svmc_pkg::S_RDFLAG || st_ff == svmc_pkg::S_POLL ||
               st_ff == svmc_pkg::S_CLRRD;
   wire isWait = st_ff == svmc_pkg::S_SETTLE || st_ff == svmc_pkg::S_FWAIT;
   assign rq.req = ~idle & ~isWait;
   assign rq.wr  = ~isRd;
   assign rq.addr =
      st_ff == svmc_pkg::S_SHARED ? `D_MONEN :
      (st_ff == svmc_pkg::S_DETRD || st_ff == svmc_pkg::S_DETWR) ? `D_DETCTL :
      (st_ff == svmc_pkg::S_OSCRD || st_ff == svmc_pkg::S_OSCWR) ? `D_CLK1 :
      ctlAddr;
   assign rq.wdata = wdMux;

   always_comb begin
      wdMux = 32'(ctlBase);
      unique case (st_ff)
         svmc_pkg::S_SHARED:
            wdMux = 32'h0000_0001 << `B_SHARED;
         svmc_pkg::S_DETWR: begin
            wdMux = rmw_ff;
            wdMux[mon2 ? `B_DET2 : `B_DET1] = 1'b1;
         end
         svmc_pkg::S_CFG:
            wdMux[`B_EN] = 1'b0;
         svmc_pkg::S_CLRF: begin
            wdMux[`B_FLAG] = 1'b0;
         end
         svmc_pkg::S_OSCWR: begin
            wdMux = rmw_ff;
            wdMux[`B_OSCSTOP] = 1'b0;
         end
         svmc_pkg::S_ENABLE:
            wdMux[`B_EN] = 1'b1;
         svmc_pkg::S_DISCARD: begin
            wdMux[`B_EN]   = 1'b1;
            wdMux[`B_FLAG] = 1'b0;
         end
         svmc_pkg::S_CLRWR: begin
            wdMux = rmw_ff;
            wdMux[`B_FLAG] = 1'b0;
         end
         default: wdMux = 32'(ctlBase);
      endcase
   end

   // Sequence of the setup, poll and clear procedures
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         svmc_pkg::S_IDLE:
            if (goSetup)     nxt_st = svmc_pkg::S_SHARED;
            else if (goPoll) nxt_st = svmc_pkg::S_POLL;
            else if (goClr)  nxt_st = svmc_pkg::S_CLRRD;
         svmc_pkg::S_SHARED:  if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_DETRD : svmc_pkg::S_IDLE;
         svmc_pkg::S_DETRD:   if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_DETWR : svmc_pkg::S_IDLE;
         svmc_pkg::S_DETWR:   if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_SETTLE : svmc_pkg::S_IDLE;
         svmc_pkg::S_SETTLE:  if (wait_ff == 16'h0000) nxt_st = svmc_pkg::S_CFG;
         svmc_pkg::S_CFG:     if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_CLRF : svmc_pkg::S_IDLE;
         svmc_pkg::S_CLRF:
            if (rq.ack) begin
               if (!ackOk)       nxt_st = svmc_pkg::S_IDLE;
               else if (useFilt) nxt_st = svmc_pkg::S_OSCRD;
               else              nxt_st = svmc_pkg::S_ENABLE;
            end
         svmc_pkg::S_OSCRD:   if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_OSCWR : svmc_pkg::S_IDLE;
         svmc_pkg::S_OSCWR:   if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_FWAIT : svmc_pkg::S_IDLE;
         svmc_pkg::S_FWAIT:   if (wait_ff == 16'h0000) nxt_st = svmc_pkg::S_ENABLE;
         svmc_pkg::S_ENABLE:  if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_RDFLAG : svmc_pkg::S_IDLE;
         svmc_pkg::S_RDFLAG:
            if (rq.ack) begin
               if (ackOk && rq.rdata[`B_FLAG] && run_ff[`C_DISC])
                  nxt_st = svmc_pkg::S_DISCARD;
               else
                  nxt_st = svmc_pkg::S_IDLE;
            end
         svmc_pkg::S_CLRRD:   if (rq.ack) nxt_st = ackOk ? svmc_pkg::S_CLRWR : svmc_pkg::S_IDLE;
         svmc_pkg::S_DISCARD, svmc_pkg::S_POLL, svmc_pkg::S_CLRWR:
            if (rq.ack) nxt_st = svmc_pkg::S_IDLE;
      endcase
   end

   wire flagRd = rq.ack & ~rq.err &
                 (st_ff == svmc_pkg::S_RDFLAG || st_ff == svmc_pkg::S_POLL);
   wire flagClr = rq.ack & ~rq.err &
                  (st_ff == svmc_pkg::S_DISCARD || st_ff == svmc_pkg::S_CLRWR);
   wire rmwLoad = rq.ack &
                  (st_ff == svmc_pkg::S_DETRD || st_ff == svmc_pkg::S_OSCRD ||
                   st_ff == svmc_pkg::S_CLRRD);
   wire finish  = ~idle & (nxt_st == svmc_pkg::S_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         cfg_ff  <= '0;
         run_ff  <= '0;
      end else begin
         pready  <= setupPh;
         prdata  <= setupPh ? rdMux : 32'h0000_0000;
         pslverr <= setupPh & ~mapped;
         if (accWr && hitCfg)
            cfg_ff <= pwdata[`C_W-1:0];
         if (goAny)
            run_ff <= cfg_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff   <= svmc_pkg::S_IDLE;
         flag_ff <= 2'b00;
         err_ff  <= 1'b0;
         done_ff <= 1'b0;
         rmw_ff  <= 32'h0000_0000;
      end else begin
         st_ff <= nxt_st;
         if (flagRd)
            flag_ff[mon2] <= rq.rdata[`B_FLAG];
         else if (flagClr)
            flag_ff[mon2] <= 1'b0;
         if (goAny)
            err_ff <= 1'b0;
         else if (rq.ack && rq.err)
            err_ff <= 1'b1;
         if (goAny)
            done_ff <= 1'b0;
         else if (finish)
            done_ff <= 1'b1;
         if (rmwLoad)
            rmw_ff <= rq.rdata;
      end
   end

   // Wait counter for detector settling and filter start-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 16'h0000;
      end else if (rq.ack && st_ff == svmc_pkg::S_DETWR) begin
         wait_ff <= 16'(SETTLE_CYC - 1);
      end else if (rq.ack && st_ff == svmc_pkg::S_OSCWR) begin
         wait_ff <= filtCyc - 16'h0001;
      end else if (isWait && wait_ff != 16'h0000) begin
         wait_ff <= wait_ff - 16'h0001;
      end
   end

   // Helpers read only by the checks below
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clrDone_ff <= 1'b0;
         spent_ff   <= 16'h0000;
      end else begin
         if (goAny)
            clrDone_ff <= 1'b0;
         else if (ackOk && st_ff == svmc_pkg::S_CLRF)
            clrDone_ff <= 1'b1;
         if (st_ff == svmc_pkg::S_FWAIT)
            spent_ff <= spent_ff + 16'h0001;
         else
            spent_ff <= 16'h0000;
      end
   end

   apb_master_eng u_eng (
      .clk      (clk),
      .rst_n    (rst_n),
      .rq       (rq.eng),
      .mPaddr   (mPaddr),
      .mPsel    (mPsel),
      .mPenable (mPenable),
      .mPwrite  (mPwrite),
      .mPwdata  (mPwdata),
      .mPrdata  (mPrdata),
      .mPready  (mPready),
      .mPslverr (mPslverr)
   );

   property p_cfg_one_write;
      @(posedge clk) disable iff (!rst_n)
      st_ff == svmc_pkg::S_CFG && rq.req |->
         !rq.wdata[`B_EN] && rq.wr && rq.addr == ctlAddr &&
         rq.wdata[`B_BYP] == !useFilt && rq.wdata[`B_RSEL] == rstUse;
   endproperty
   a_cfg_one_write: assert property (p_cfg_one_write)
      else $error("options write wrong or enabled");

   property p_reset_edge;
      @(posedge clk) disable iff (!rst_n)
      st_ff == svmc_pkg::S_CFG && rstUse |-> rq.wdata[`B_EDGE];
   endproperty
   a_reset_edge: assert property (p_reset_edge)
      else $error("reset use without edge bit set");

   property p_shared_first;
      @(posedge clk) disable iff (!rst_n)
      goSetup |=> st_ff == svmc_pkg::S_SHARED && rq.addr == `D_MONEN
                  && rq.wdata[`B_SHARED];
   endproperty
   a_shared_first: assert property (p_shared_first)
      else $error("setup did not start with shared enable");

   property p_clear_before_enable;
      @(posedge clk) disable iff (!rst_n)
      st_ff == svmc_pkg::S_ENABLE |-> clrDone_ff;
   endproperty
   a_clear_before_enable: assert property (p_clear_before_enable)
      else $error("monitor enabled before flag clear");

   property p_osc_on;
      @(posedge clk) disable iff (!rst_n)
      st_ff == svmc_pkg::S_OSCWR |->
         useFilt && !rq.wdata[`B_OSCSTOP] && rq.addr == `D_CLK1;
   endproperty
   a_osc_on: assert property (p_osc_on)
      else $error("oscillator stop not cleared");

   property p_filter_wait;
      @(posedge clk) disable iff (!rst_n)
      st_ff == svmc_pkg::S_FWAIT ##1 st_ff == svmc_pkg::S_ENABLE |->
         $past(spent_ff) + 16'h0001 == filtCyc;
   endproperty
   a_filter_wait: assert property (p_filter_wait)
      else $error("filter wait not three sampling clocks");

   property p_discard;
      @(posedge clk) disable iff (!rst_n)
      st_ff == svmc_pkg::S_RDFLAG && ackOk && rq.rdata[`B_FLAG] &&
      run_ff[`C_DISC] |=> st_ff == svmc_pkg::S_DISCARD ##[1:1000] !rq.req;
   endproperty
   a_discard: assert property (p_discard)
      else $error("early crossing not discarded");
endmodule
`default_nettype wire

//--- tb/dev_model.sv
// Behavioural supply-monitor device: its registers behind an APB slave port.
// Assumes the host master runs on clk; crossIn stands for a threshold crossing.
`include "svmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dev_model #(
   parameter logic [7:0] CLK1_RST = 8'hD0
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  mPaddr,
   input  wire logic        mPsel,
   input  wire logic        mPenable,
   input  wire logic        mPwrite,
   input  wire logic [31:0] mPwdata,
   output var  logic [31:0] mPrdata,
   output var  logic        mPready,
   output var  logic        mPslverr,
   input  wire logic        slow,
   input  wire logic        errNext,
   input  wire logic        crossIn,
   output var  logic [1:0]  irqOut
);
   logic [7:0]  monEn_ff, det_ff, clk1_ff, m1_ff, m2_ff, regRd;
   logic [31:0] last_ff;
   logic [1:0]  wait_ff;
   logic        wrHit;
   logic [2:0]  div_ff;
   logic [1:0]  filt_ff, prev_ff, hit;
   // Filter samples crossIn on its sampling tick; the bypass bit skips it
   assign hit[0] = m1_ff[`B_BYP] ? crossIn : filt_ff[0];
   assign hit[1] = m2_ff[`B_BYP] ? crossIn : filt_ff[1];
   always_comb begin
      case (mPaddr)
         `D_MONEN:  regRd = monEn_ff;
         `D_DETCTL: regRd = det_ff;
         `D_CLK1:   regRd = clk1_ff;
         `D_M1CTL:  regRd = m1_ff;
         `D_M2CTL:  regRd = m2_ff;
         default:   regRd = 8'h00;
      endcase
   end
   assign mPready  = mPsel && mPenable && wait_ff == 2'h0;
   assign mPslverr = mPready && errNext;
   // Released data lines show the inverse of the last answer
   assign mPrdata  = mPready ? {24'h0, regRd} : ~last_ff;
   assign wrHit    = mPready && mPwrite && !errNext;
   // Request only once armed and set for interrupt
   assign irqOut[0] = hit[0] && !prev_ff[0] && monEn_ff[0] && m1_ff[`B_EN]
                      && !m1_ff[`B_RSEL];
   assign irqOut[1] = hit[1] && !prev_ff[1] && monEn_ff[0] && m2_ff[`B_EN]
                      && !m2_ff[`B_RSEL];
   // Flag write: zero clears, one keeps
   function automatic logic [7:0] ctlWr(input logic [7:0] old, input logic [31:0] d);
      return {d[7:3], d[2] & old[2], d[1:0]};
   endfunction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         monEn_ff <= 8'h00;
         det_ff   <= 8'h00;
         clk1_ff  <= CLK1_RST;
         m1_ff    <= 8'h00;
         m2_ff    <= 8'h00;
         last_ff  <= 32'h0;
         wait_ff  <= 2'h0;
         div_ff   <= 3'h0;
         filt_ff  <= 2'h0;
         prev_ff  <= 2'h0;
      end else begin
         div_ff  <= div_ff + 3'h1;
         prev_ff <= hit;
         if ((div_ff & ((3'h1 << m1_ff[`B_FSEL+1:`B_FSEL]) - 3'h1)) == 3'h0) filt_ff[0] <= crossIn;
         if ((div_ff & ((3'h1 << m2_ff[`B_FSEL+1:`B_FSEL]) - 3'h1)) == 3'h0) filt_ff[1] <= crossIn;
         if (mPsel && !mPenable) wait_ff <= slow ? 2'($urandom_range(3, 0)) : 2'h0;
         else if (mPsel && wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
         if (mPready) last_ff <= mPrdata;
         if (hit[0] && det_ff[`B_DET1]) m1_ff[`B_FLAG] <= 1'b1;
         if (hit[1] && det_ff[`B_DET2]) m2_ff[`B_FLAG] <= 1'b1;
         if (wrHit) begin
            case (mPaddr)
               `D_MONEN:  monEn_ff <= mPwdata[7:0];
               `D_DETCTL: det_ff <= mPwdata[7:0];
               `D_CLK1:   clk1_ff <= mPwdata[7:0];
               `D_M1CTL:  m1_ff <= ctlWr(m1_ff, mPwdata);
               `D_M2CTL:  m2_ff <= ctlWr(m2_ff, mPwdata);
               default:   ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the supply-monitor host against a device model.
// Assumes the design, its package and svmc_defs.svh are compiled first.
`include "svmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int SETTLE = 20;
   localparam int FBASE  = 5;
   localparam logic [31:0] BYTE = 32'hFF;
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [31:0] mask;
   } xfer_t;
   logic             clk, rst_n, psel, penable, pwrite, slow, errNext, crossIn, lastErr;
   logic [7:0]       paddr, detM, clkM;
   logic [31:0]      pwdata, rdv;
   wire logic [31:0] prdata, mPwdata, mPrdata;
   wire logic [7:0]  mPaddr;
   wire logic        pready, pslverr, mPsel, mPenable, mPwrite, mPready, mPslverr;
   xfer_t            got[$], exp[$];
   int               stamp[$];
   int               cyc = 0;
   int               miscompares = 0;
   int               samples_checked = 0;

   supply_voltage_monitor_ctrl #(.SETTLE_CYC(SETTLE), .FILT_BASE(FBASE)) dut (
      .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mPaddr(mPaddr), .mPsel(mPsel), .mPenable(mPenable), .mPwrite(mPwrite), .mPwdata(mPwdata),
      .mPrdata(mPrdata), .mPready(mPready), .mPslverr(mPslverr));
   dev_model dev (
      .clk(clk), .rst_n(rst_n), .mPaddr(mPaddr), .mPsel(mPsel), .mPenable(mPenable),
      .mPwrite(mPwrite), .mPwdata(mPwdata), .mPrdata(mPrdata), .mPready(mPready),
      .mPslverr(mPslverr), .slow(slow), .errNext(errNext), .crossIn(crossIn), .irqOut());

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Record every finished device transfer with its cycle
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (mPsel && mPenable && mPready) begin
         got.push_back(xfer_t'{mPwrite, mPaddr, mPwdata, 32'h0});
         stamp.push_back(cyc);
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One APB transfer, entered just after a rising edge, one idle cycle after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         conclude();
      end
      rdv = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitIdle();
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      do begin
         apb(1'b0, `A_STAT, 32'h0);
         n++;
      end while (rdv[`S_BUSY] !== 1'b0 && n < 500);
      if (n >= 500) begin
         miscompares++;
         conclude();
      end
   endtask
   function automatic void push(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      exp.push_back(xfer_t'{w, a, d & m, m});
   endfunction
   function automatic void expSetup(input logic [6:0] c, input logic fl);
      logic [7:0] cv, ca;
      cv = {c[`C_EDGE] | c[`C_RST], c[`C_RST], c[5:4], 1'b0, 1'b1, !c[`C_FILT], 1'b0};
      ca = c[`C_MON] ? `D_M2CTL : `D_M1CTL;
      detM = detM | (c[`C_MON] ? 8'h80 : 8'h40);
      exp.delete();
      push(1'b1, `D_MONEN, 32'h1, 32'h1);
      push(1'b0, `D_DETCTL, 32'h0, 32'h0);
      push(1'b1, `D_DETCTL, detM, BYTE);
      push(1'b1, ca, cv, BYTE);
      push(1'b1, ca, cv & 8'hFB, BYTE);
      if (c[`C_FILT]) begin
         clkM = clkM & 8'hEF;
         push(1'b0, `D_CLK1, 32'h0, 32'h0);
         push(1'b1, `D_CLK1, clkM, BYTE);
      end
      push(1'b1, ca, cv | 8'h01, BYTE);
      push(1'b0, ca, 32'h0, 32'h0);
      if (fl && c[`C_DISC]) push(1'b1, ca, cv & 8'hFB | 8'h01, BYTE);
   endfunction
   task automatic cmdRun(input logic [31:0] cmd, input logic dup);
      got.delete();
      stamp.delete();
      apb(1'b1, `A_CMD, cmd);
      // A second command while busy must leave no trace
      if (dup) apb(1'b1, `A_CMD, 32'h2);
      waitIdle();
      chk(got.size(), exp.size());
      foreach (exp[i]) begin
         if (i < got.size()) begin
            chk(got[i].wr, exp[i].wr);
            chk(got[i].addr, exp[i].addr);
            chk(got[i].data & exp[i].mask, exp[i].data);
         end
      end
   endtask

   initial begin
      #400000;
      miscompares++;
      conclude();
   end
   initial begin
      logic [6:0] c;
      logic       fl;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      errNext = 1'b0;
      crossIn = 1'b0;
      detM = 8'h00;
      clkM = 8'hD0;
      void'($urandom(32'h1E69));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `A_STAT, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rdv, 32'h0);
      chk(lastErr, 32'h1);
      for (int i = 0; i < 9; i++) begin
         c = i == 0 ? 7'h07 : i == 1 ? 7'h71 : i == 2 ? 7'h06 : 7'($urandom);
         fl = i < 3 ? 1'b1 : 1'($urandom);
         slow <= 1'($urandom);
         crossIn <= fl;
         apb(1'b1, `A_CFG, {25'h0, c});
         apb(1'b0, `A_CFG, 32'h0);
         chk(rdv, {25'h0, c});
         expSetup(c, fl);
         cmdRun(32'h1, i == 0);
         chk(stamp[3] - stamp[2] >= SETTLE, 32'h1);
         if (c[`C_FILT]) chk(stamp[7] - stamp[6] >= (FBASE << c[5:4]), 32'h1);
         chk({rdv[`S_DONE], rdv[`S_ERR], rdv[`S_BUSY]}, 32'h4);
         chk(rdv[`S_F1 + c[0]], fl && !c[`C_DISC]);
      end
      // Monitor 1 flag stays up after a short crossing ends, then is cleared
      apb(1'b1, `A_CFG, 32'h0);
      crossIn <= 1'b1;
      repeat (10) @(posedge clk);
      crossIn <= 1'b0;
      exp.delete();
      push(1'b0, `D_M1CTL, 32'h0, 32'h0);
      cmdRun(32'h2, 1'b0);
      chk(rdv[`S_F1], 32'h1);
      push(1'b1, `D_M1CTL, 32'h0, 32'h4);
      cmdRun(32'h4, 1'b0);
      exp.delete();
      push(1'b0, `D_M1CTL, 32'h0, 32'h0);
      cmdRun(32'h2, 1'b0);
      chk(rdv[`S_F1], 32'h0);
      // Device error aborts the setup at its first transfer
      errNext <= 1'b1;
      exp.delete();
      push(1'b1, `D_MONEN, 32'h1, 32'h1);
      cmdRun(32'h1, 1'b0);
      chk({rdv[`S_ERR], rdv[`S_BUSY]}, 32'h2);
      errNext <= 1'b0;
      conclude();
   end
endmodule
`default_nettype wire
